// ==== hdl/config_mode_pkg.sv ====
package config_mode_pkg;

  // ----------------------------------------------------------------
  // Register map (indices on the plain register port and over SMBus)
  // ----------------------------------------------------------------
  localparam int           LANES          = 6;
  localparam logic [3:0]   OFS_LANE0      = 4'h0;
  localparam logic [3:0]   OFS_STATUS     = 4'h6;
  localparam logic [7:0]   LANE_RESET     = 8'h00;
  localparam int           STAT_MODE_BIT  = 2;
  localparam int           STAT_RATE_LSB  = 0;

  // ----------------------------------------------------------------
  // Management bus constants
  // ----------------------------------------------------------------
  // Upper three address bits, value arbitrary
  localparam logic [2:0]   SMB_ADDR_BASE  = 3'h5;
  localparam logic [3:0]   SMB_BITS       = 4'h8;

  // ----------------------------------------------------------------
  // Shared pin positions and synchroniser width
  // ----------------------------------------------------------------
  localparam int           PIN_SDA        = 2;
  localparam int           PIN_SCL        = 3;
  localparam int           SYNC_W         = 15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_LOW   = 2'b00,
    LVL_FLOAT = 2'b01,
    LVL_HIGH  = 2'b10
  } level_t;

  typedef enum logic [1:0] {
    RATE_3G   = 2'b00,
    RATE_6G   = 2'b01,
    RATE_AUTO = 2'b10
  } rate_t;

  typedef enum logic [3:0] {
    SMB_IDLE     = 4'h0,
    SMB_ADDR     = 4'h1,
    SMB_ACK_ADDR = 4'h2,
    SMB_REG      = 4'h3,
    SMB_ACK_REG  = 4'h4,
    SMB_WDATA    = 4'h5,
    SMB_ACK_W    = 4'h6,
    SMB_RDATA    = 4'h7,
    SMB_RACK     = 4'h8
  } smb_state_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } tri_pin_t;

  typedef struct packed {
    logic [3:0] eq;
    logic [3:0] dem;
  } lane_cfg_t;

  typedef struct packed {
    lane_cfg_t [5:0] lane;
    rate_t           rate;
  } settings_t;

endpackage : config_mode_pkg

// ==== hdl/config_mode_pin_select.sv ====
// Behaviour
// - Mode high opens registers to management bus
// - Mode low blocks lane registers, uses control pins
// - Register mode turns shared pins into SDA/SCL
// - Register mode reads four pins as address
// - Pin mode: equalization strap per port, both lanes
// - Pin mode: de-emphasis strap per port, both lanes
// - Straps honoured only while mode is low
// - Register mode gives independent per-lane settings
// - Rate pin picks data rate in both modes
// - Three-level pins decode high, low, float
// - Undriven mode pin reads low, pin mode
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module config_mode_pin_select (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          link_clk,
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire logic                          config_source_select,
  input  wire config_mode_pkg::tri_pin_t [5:0] shared_pin,
  input  wire config_mode_pkg::tri_pin_t     rate_pin,
  output logic                               sda_out,
  output logic                               sda_oe,
  output config_mode_pkg::lane_cfg_t [5:0]   lane_cfg,
  output config_mode_pkg::rate_t             rate_sel
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // three-level decode
  function automatic config_mode_pkg::level_t tri_decode(input config_mode_pkg::tri_pin_t p);
    if (p.hi)
      return config_mode_pkg::LVL_HIGH;
    else if (p.lo)
      return config_mode_pkg::LVL_LOW;
    else
      return config_mode_pkg::LVL_FLOAT;
  endfunction : tri_decode

  function automatic logic [3:0] strap_setting(input config_mode_pkg::tri_pin_t p);
    config_mode_pkg::level_t lvl;
    lvl = tri_decode(p);
    return {2'b00, lvl};
  endfunction : strap_setting

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [config_mode_pkg::SYNC_W-1:0] pin_raw;
  logic [config_mode_pkg::SYNC_W-1:0] sync1;
  logic [config_mode_pkg::SYNC_W-1:0] sync2;
  logic [config_mode_pkg::SYNC_W-1:0] sync3;
  logic [config_mode_pkg::SYNC_W-1:0] pin_clean;

  config_mode_pkg::tri_pin_t [5:0]    shared_clean;
  config_mode_pkg::tri_pin_t          rate_clean;
  logic                               mode;

  // pull-down makes an open mode pin low
  assign pin_raw = {config_source_select, rate_pin, shared_pin};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < config_mode_pkg::SYNC_W; gi++)
    begin : g_clean
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_clean[gi] <= 1'b0;
        else if (sync2[gi] == sync3[gi])
          pin_clean[gi] <= sync3[gi];
      end
    end
  endgenerate

  assign shared_clean = pin_clean[11:0];
  assign rate_clean   = pin_clean[13:12];
  assign mode         = pin_clean[14];

  // ----------------------------------------------------------------
  // Shared pin roles in register mode
  // ----------------------------------------------------------------
  logic       sda_in;
  logic       scl_in;
  logic       sda_prev;
  logic       scl_prev;
  logic [6:0] slave_addr;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;
  logic       scl_fall;

  // shared pins carry SDA and SCL
  assign sda_in = shared_clean[config_mode_pkg::PIN_SDA].hi;
  assign scl_in = shared_clean[config_mode_pkg::PIN_SCL].hi;

  assign slave_addr = {config_mode_pkg::SMB_ADDR_BASE, shared_clean[5].hi, shared_clean[4].hi,
                       shared_clean[1].hi, shared_clean[0].hi};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end
    else
    begin
      sda_prev <= sda_in;
      scl_prev <= scl_in;
    end
  end

  assign start_ev = mode & scl_in & scl_prev & sda_prev & ~sda_in;
  assign stop_ev  = mode & scl_in & scl_prev & ~sda_prev & sda_in;
  assign scl_rise = mode & scl_in & ~scl_prev;
  assign scl_fall = mode & ~scl_in & scl_prev;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  config_mode_pkg::lane_cfg_t [5:0] lane_reg;
  config_mode_pkg::rate_t           rate_dec;
  logic [3:0]                       ptr;
  logic                             smb_wr;
  logic [7:0]                       shift;

  function automatic logic [7:0] reg_value(input logic [3:0] idx,
                                           input config_mode_pkg::lane_cfg_t [5:0] regs,
                                           input logic md,
                                           input config_mode_pkg::rate_t rt);
    logic [7:0] v;
    v = 8'h00;
    if (idx < config_mode_pkg::OFS_STATUS)
      v = md ? regs[idx[2:0]] : 8'h00;
    else if (idx == config_mode_pkg::OFS_STATUS)
    begin
      v[config_mode_pkg::STAT_MODE_BIT] = md;
      v[config_mode_pkg::STAT_RATE_LSB +: 2] = rt;
    end
    return v;
  endfunction : reg_value

  always_comb
  begin
    unique case (tri_decode(rate_clean))
      config_mode_pkg::LVL_HIGH:  rate_dec = config_mode_pkg::RATE_6G;
      config_mode_pkg::LVL_FLOAT: rate_dec = config_mode_pkg::RATE_AUTO;
      config_mode_pkg::LVL_LOW:   rate_dec = config_mode_pkg::RATE_3G;
      default:                    rate_dec = config_mode_pkg::RATE_3G;
    endcase
  end

  generate
    for (gi = 0; gi < config_mode_pkg::LANES; gi++)
    begin : g_lane_reg
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          lane_reg[gi] <= config_mode_pkg::LANE_RESET;
        else if (mode && smb_wr && ptr == 4'(gi))
          lane_reg[gi] <= shift;
        else if (mode && reg_wr && reg_addr == 4'(gi))
          lane_reg[gi] <= reg_wdata;
      end
    end
  endgenerate

  // lane registers read zero in pin mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= reg_value(reg_addr, lane_reg, mode, rate_dec);
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Management bus slave
  // ----------------------------------------------------------------
  config_mode_pkg::smb_state_t state;
  logic [3:0]                  bit_cnt;
  logic                        rw;
  logic [7:0]                  rd_byte;

  assign rd_byte = reg_value(ptr, lane_reg, mode, rate_dec);
  assign sda_out = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      smb_wr <= 1'b0;
    else
      smb_wr <= scl_fall && !start_ev && !stop_ev && state == config_mode_pkg::SMB_WDATA &&
                bit_cnt == config_mode_pkg::SMB_BITS;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= config_mode_pkg::SMB_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 4'h0;
      rw      <= 1'b0;
      sda_oe  <= 1'b0;
    end
    // bus held idle in pin mode
    else if (!mode || stop_ev)
    begin
      state  <= config_mode_pkg::SMB_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_ev)
    begin
      state   <= config_mode_pkg::SMB_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (state)
        config_mode_pkg::SMB_ADDR, config_mode_pkg::SMB_REG, config_mode_pkg::SMB_WDATA:
        begin
          shift   <= {shift[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end
        config_mode_pkg::SMB_RACK:
        begin
          if (sda_in)
            state <= config_mode_pkg::SMB_IDLE;
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state)
        config_mode_pkg::SMB_ADDR:
        begin
          if (bit_cnt == config_mode_pkg::SMB_BITS)
          begin
            if (shift[7:1] == slave_addr)
            begin
              state  <= config_mode_pkg::SMB_ACK_ADDR;
              rw     <= shift[0];
              sda_oe <= 1'b1;
            end
            else
              state <= config_mode_pkg::SMB_IDLE;
          end
        end
        config_mode_pkg::SMB_REG:
        begin
          if (bit_cnt == config_mode_pkg::SMB_BITS)
          begin
            ptr    <= shift[3:0];
            state  <= config_mode_pkg::SMB_ACK_REG;
            sda_oe <= 1'b1;
          end
        end
        config_mode_pkg::SMB_WDATA:
        begin
          if (bit_cnt == config_mode_pkg::SMB_BITS)
          begin
            state  <= config_mode_pkg::SMB_ACK_W;
            sda_oe <= 1'b1;
          end
        end
        config_mode_pkg::SMB_ACK_ADDR:
        begin
          if (rw)
          begin
            state   <= config_mode_pkg::SMB_RDATA;
            shift   <= rd_byte;
            sda_oe  <= ~rd_byte[7];
            bit_cnt <= 4'h1;
          end
          else
          begin
            state   <= config_mode_pkg::SMB_REG;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
          end
        end
        config_mode_pkg::SMB_ACK_REG, config_mode_pkg::SMB_ACK_W:
        begin
          if (state == config_mode_pkg::SMB_ACK_W)
            ptr <= ptr + 4'h1;
          state   <= config_mode_pkg::SMB_WDATA;
          bit_cnt <= 4'h0;
          sda_oe  <= 1'b0;
        end
        config_mode_pkg::SMB_RDATA:
        begin
          if (bit_cnt == config_mode_pkg::SMB_BITS)
          begin
            state  <= config_mode_pkg::SMB_RACK;
            sda_oe <= 1'b0;
            ptr    <= ptr + 4'h1;
          end
          else
          begin
            sda_oe  <= ~shift[6];
            shift   <= {shift[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        config_mode_pkg::SMB_RACK:
        begin
          state   <= config_mode_pkg::SMB_RDATA;
          shift   <= rd_byte;
          sda_oe  <= ~rd_byte[7];
          bit_cnt <= 4'h1;
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  config_mode_pkg::settings_t eff;

  generate
    for (gi = 0; gi < config_mode_pkg::LANES; gi++)
    begin : g_eff
      always_comb
      begin
        if (mode)
          eff.lane[gi] = lane_reg[gi];
        else
        begin
          eff.lane[gi].eq  = strap_setting(shared_clean[2 * (gi / 2)]);
          eff.lane[gi].dem = strap_setting(shared_clean[2 * (gi / 2) + 1]);
        end
      end
    end
  endgenerate

  assign eff.rate = rate_dec;

  // ----------------------------------------------------------------
  // Crossing into the link domain
  // ----------------------------------------------------------------
  config_mode_pkg::settings_t held;
  logic                       req;
  logic                       ack_s1;
  logic                       ack_s2;
  logic                       req_s1;
  logic                       req_s2;
  logic                       ack_l;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held   <= '0;
      req    <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_l;
      ack_s2 <= ack_s1;
      if (req == ack_s2 && held != eff)
      begin
        held <= eff;
        req  <= ~req;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      ack_l    <= 1'b0;
      lane_cfg <= '0;
      rate_sel <= config_mode_pkg::RATE_3G;
    end
    else
    begin
      req_s1 <= req;
      req_s2 <= req_s1;
      if (req_s2 != ack_l)
      begin
        lane_cfg <= held.lane;
        rate_sel <= held.rate;
        ack_l    <= req_s2;
      end
    end
  end

endmodule : config_mode_pin_select

`default_nettype wire

// ==== tb/config_mode_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module config_mode_sva (
  input wire logic                            core_clk,
  input wire logic                            rst_n,
  input wire logic                            link_clk,
  input wire logic [3:0]                      reg_addr,
  input wire logic                            reg_rd,
  input wire logic [7:0]                      reg_rdata,
  input wire logic                            config_source_select,
  input wire config_mode_pkg::tri_pin_t [5:0] shared_pin,
  input wire logic                            sda_out,
  input wire logic                            sda_oe,
  input wire config_mode_pkg::rate_t          rate_sel
);

  // ----------------------------------------------------------------
  // Age of the mode input
  // ----------------------------------------------------------------
  logic       mode_q;
  logic [3:0] mode_cnt;
  logic       settled;

  assign settled = (mode_cnt == 4'hF);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q   <= 1'b0;
      mode_cnt <= 4'h0;
    end
    else
    begin
      mode_q <= config_source_select;
      if (mode_q != config_source_select)
        mode_cnt <= 4'h0;
      else if (!settled)
        mode_cnt <= mode_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_rdata_slot:
    assert property (@(posedge core_clk) disable iff (!rst_n) !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
  a_unmapped_zero:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr > config_mode_pkg::OFS_STATUS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  a_status_mode:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      settled && reg_rd && reg_addr == config_mode_pkg::OFS_STATUS
      |=> reg_rdata[config_mode_pkg::STAT_MODE_BIT] == $past(config_source_select))
      else $error("status mode bit wrong");
  a_lane_blocked:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      settled && !config_source_select && reg_rd && reg_addr < config_mode_pkg::OFS_STATUS |=> reg_rdata == 8'h00)
      else $error("lane read open in pin mode");
  a_sda_quiet:
    assert property (@(posedge core_clk) disable iff (!rst_n) settled && !config_source_select |-> !sda_oe)
      else $error("data line driven in pin mode");
  a_sda_open:
    assert property (@(posedge core_clk) disable iff (!rst_n) sda_out == 1'b0)
      else $error("data line driven high");
  a_ack_on_low:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(sda_oe) |-> !shared_pin[config_mode_pkg::PIN_SCL].hi)
      else $error("acknowledge raised while clock high");
  a_ack_hold:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      shared_pin[config_mode_pkg::PIN_SCL].hi [*8] |-> $stable(sda_oe))
      else $error("data line moved while clock high");
  a_rate_code:
    assert property (@(posedge link_clk) disable iff (!rst_n) rate_sel != 2'b11)
      else $error("illegal rate code");

  c_ack: cover property (@(posedge core_clk) $rose(sda_oe));
  c_status: cover property (@(posedge core_clk)
    reg_rd && reg_addr == config_mode_pkg::OFS_STATUS && config_source_select);
  c_pin_read: cover property (@(posedge core_clk) reg_rd && !config_source_select);

endmodule : config_mode_sva

bind config_mode_pin_select config_mode_sva chk_u (
  .core_clk, .rst_n, .link_clk, .reg_addr, .reg_rd, .reg_rdata,
  .config_source_select, .shared_pin, .sda_out, .sda_oe, .rate_sel);

`default_nettype wire

// ==== tb/smbus_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model (
  input wire logic core_clk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_low
);

  logic [7:0] got;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_c

  task automatic start;
    sda_low <= 1'b1;
    wait_c(12);
    scl <= 1'b0;
    wait_c(4);
  endtask : start

  task automatic stop;
    sda_low <= 1'b1;
    wait_c(12);
    scl <= 1'b1;
    wait_c(12);
    sda_low <= 1'b0;
    wait_c(12);
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--)
    begin
      sda_low <= (i >= 0) ? !b[i & 7] : 1'b0;
      wait_c(12);
      scl <= 1'b1;
      wait_c(12);
      ack = !sda;
      if (i >= 0)
        got = {got[6:0], sda};
      scl <= 1'b0;
      wait_c(4);
    end
  endtask : send

endmodule : smbus_host_model

`default_nettype wire

// ==== tb/config_mode_pin_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module config_mode_pin_select_tb;

  logic                            core_clk;
  logic                            link_clk;
  logic                            rst_n;
  logic                            reg_wr;
  logic                            reg_rd;
  logic                            config_source_select;
  logic [3:0]                      reg_addr;
  logic [7:0]                      reg_wdata;
  logic [7:0]                      reg_rdata;
  logic [5:0][1:0]                 strap;
  logic [2:0][1:0]                 lvc = {2'b01, 2'b10, 2'b00};
  config_mode_pkg::tri_pin_t [5:0] shared_pin;
  config_mode_pkg::tri_pin_t       rate_pin;
  config_mode_pkg::lane_cfg_t [5:0] lane_cfg;
  config_mode_pkg::rate_t          rate_sel;
  logic                            sda_out;
  logic                            sda_oe;
  logic                            scl;
  logic                            sda_low;
  logic                            ack;
  wire logic                       sda = !(sda_low || sda_oe);
  int                              fail_count;
  int                              checks_done;

  // ----------------------------------------------------------------
  // Clocks, pins, instances
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  function automatic config_mode_pkg::tri_pin_t pin_of(input logic [1:0] c);
    return '{hi: c[1], lo: c == 2'b00};
  endfunction : pin_of

  always_comb
  begin
    for (int i = 0; i < 6; i++)
      shared_pin[i] = pin_of(strap[i]);
    if (config_source_select)
    begin
      shared_pin[config_mode_pkg::PIN_SDA] = '{hi: sda, lo: !sda};
      shared_pin[config_mode_pkg::PIN_SCL] = '{hi: scl, lo: !scl};
    end
  end

  config_mode_pin_select dut_u (
    .core_clk, .rst_n, .link_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .config_source_select, .shared_pin, .rate_pin, .sda_out, .sda_oe, .lane_cfg, .rate_sel);

  smbus_host_model host_u (.core_clk, .sda, .scl, .sda_low);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rd

  task automatic settle;
    repeat (40) @(posedge core_clk);
  endtask : settle

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    config_source_select = 1'b0;
    strap = 12'b10_01_10_00_01_10;
    rate_pin = pin_of(2'b01);
    repeat (10) @(posedge core_clk);
    check(lane_cfg, 48'h0);
    check(sda_oe, 1'b0);
    rst_n <= 1'b1;
    #1 settle;
    check(lane_cfg, 48'h1212_0202_2121);
    wr(4'h0, 8'h5A);
    rd(4'h0, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      rate_pin <= pin_of(lvc[k]);
      settle;
      check(rate_sel, 48'(k));
      rd(4'h6, 8'(k));
    end
    config_source_select <= 1'b1;
    settle;
    rd(4'h0, 8'h00);
    for (int i = 0; i < 6; i++)
      wr(4'(i), 8'(8'h11 * (i + 1)));
    wr(4'h6, 8'hFF);
    for (int i = 0; i < 6; i++)
      rd(4'(i), 8'(8'h11 * (i + 1)));
    rd(4'h6, 8'h06);
    rd(4'hF, 8'h00);
    settle;
    check(lane_cfg, 48'h6655_4433_2211);
    host_u.start;
    host_u.send({config_mode_pkg::SMB_ADDR_BASE, 4'h9, 1'b0}, ack);
    check(ack, 1'b1);
    host_u.send(8'h03, ack);
    check(ack, 1'b1);
    host_u.send(8'hC3, ack);
    check(ack, 1'b1);
    host_u.stop;
    rd(4'h3, 8'hC3);
    host_u.start;
    host_u.send({config_mode_pkg::SMB_ADDR_BASE, 4'h9, 1'b1}, ack);
    check(ack, 1'b1);
    host_u.send(8'hFF, ack);
    check(host_u.got, 8'h55);
    host_u.stop;
    host_u.start;
    host_u.send({config_mode_pkg::SMB_ADDR_BASE, 4'h6, 1'b0}, ack);
    check(ack, 1'b0);
    host_u.stop;
    config_source_select <= 1'b0;
    settle;
    check(lane_cfg, 48'h1212_0202_2121);
    rd(4'h3, 8'h00);
    stop_test;
  end

endmodule : config_mode_pin_select_tb

`default_nettype wire
